/* File: logic/ats_regs.svh */
// Register offsets, field positions, reset values and timing figures
// of the antenna tuning sequencer.
// Assumes a 100 MHz clock and an APB master with 32-bit data.
//
// What this block does
// - Coarse start reroutes drive to coarse discriminators.
// - Coarse discriminators feed both servo amplifiers.
// - Coarse start clears every capacitor solenoid.
// - Changeover waits for servo-stopped detector.
// - Changeover selects capacitors from position switches.
// - Then drive returns, servos take fine discriminators.
// - Phase steers tuning coil, amplitude loading coil.
// - Integrator switched in after 1.5 s fine.
// - Ready three seconds after changeover.
// - At ready, link option inhibits or keeps servos.
// - Manual mode inhibits servos, range from switch.
// - Four lines; manual or outside party selects.
// - Manual override forces ready active.
// - Range or line change sequenced without RF.
// - Eight ranges; top two short inductor sections.
// - Whole tuning sequence ends within eight seconds.
`ifndef ATS_REGS_SVH
`define ATS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ATS_CTRL_OFF 8'h00
`define ATS_SEL_OFF 8'h04
`define ATS_STAT_OFF 8'h08
`define ATS_INT_STAT_OFF 8'h0C
`define ATS_INT_MASK_OFF 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATS_CTRL_START 0
`define ATS_CTRL_MANUAL 1
`define ATS_CTRL_OVR 2
`define ATS_CTRL_SRVOFF 3
`define ATS_SEL_MRANGE 0
`define ATS_SEL_MLINE 4
`define ATS_SEL_ALINE 8
`define ATS_EV_READY 0
`define ATS_EV_CHANGE 1
`define ATS_EV_FAULT 2
`define ATS_EV_SWITCH 3

// ----------------------------------------------------------------
// Reset values and decoding constants
// ----------------------------------------------------------------
`define ATS_SEL_RST 32'h0000_0000
`define ATS_MASK_RST 4'h0
`define ATS_SHORT_MIN_RANGE 3'h6

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define ATS_CLK_HZ 100000000
`define ATS_INTEG_MS 1500
`define ATS_READY_MS 3000
`define ATS_MAX_MS 8000
`define ATS_SWITCH_MS 20

`endif

/* File: logic/ats_pkg.sv */
// Types shared by the tuning sequencer files.
// Assumes ats_regs.svh is on the include path.
`include "ats_regs.svh"

package ats_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [2:0] ats_range_t;
  typedef logic [1:0] ats_line_t;
  typedef logic [3:0] ats_cap_t;

  // Sequencer phases
  typedef enum logic [2:0] {ST_IDLE, ST_COARSE, ST_QUIET, ST_MOVE, ST_FINE, ST_READY} ats_state_e;

  // Elapsed-time counter state
  typedef struct packed {
    logic [31:0] count;
  } ats_tmr_s;

  // Capacitor solenoids for a range; zero is kept for the neutral bank
  function automatic ats_cap_t ats_cap_bits(input ats_range_t rng);
    ats_cap_bits = 4'(rng) + 4'h1;
  endfunction

  // Inductor short solenoids, only on the two highest ranges
  function automatic logic [1:0] ats_short_bits(input ats_range_t rng);
    ats_short_bits = (rng >= `ATS_SHORT_MIN_RANGE) ? 2'h3 : 2'h0;
  endfunction

endpackage

/* File: logic/ats_tmr_if.sv */
// Link between the sequencer and one of its elapsed-time counters.
// Assumes one clock shared by both ends.
interface ats_tmr_if;
  logic clr; // Restart counting from zero
  logic [31:0] elapsed; // Cycles since the last restart, saturating
  modport owner (output clr, input elapsed);
  modport timer (input clr, output elapsed);
endinterface

/* File: logic/ats_timer.sv */
// Saturating elapsed-cycle counter used for phase and watchdog timing.
// Assumes clr is a combinational request from the owner.
module ats_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Owner link
  ats_tmr_if.timer bus
);
  import ats_pkg::*;

  ats_tmr_s r; // Registered state
  ats_tmr_s n; // Next state

  // Count up, restart on request; saturation keeps long waits safe
  always_comb
  begin
    n = r;
    if (bus.clr)
    begin
      n.count = 32'h0000_0000;
    end
    else if (r.count != 32'hFFFF_FFFF)
    begin
      n.count = r.count + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign bus.elapsed = r.count;

endmodule

/* File: logic/ats_top.sv */
// Antenna tuning sequencer: coarse/fine servo sequencing, capacitor and
// line switching under RF inhibit except the capacitor clear at coarse start, APB registers and one interrupt.
// Assumes synchronous inputs, an APB master and a 100 MHz clock.
//
// The register addresses and the APB register port were decided locally.
`include "ats_regs.svh"

module ats_top
#(
  parameter logic [31:0] SWITCH_CYC = 32'(`ATS_SWITCH_MS * (`ATS_CLK_HZ / 1000)),
  parameter logic [31:0] INTEG_CYC = 32'(`ATS_INTEG_MS * (`ATS_CLK_HZ / 1000)),
  parameter logic [31:0] READY_CYC = 32'(`ATS_READY_MS * (`ATS_CLK_HZ / 1000)),
  parameter logic [31:0] MAX_CYC = 32'(`ATS_MAX_MS * (`ATS_CLK_HZ / 1000))
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer inputs
  input wire logic tune_req,
  input wire logic servo_low,
  input wire ats_pkg::ats_range_t switch_range,
  // Drive and servo routing
  output logic drive_to_coarse,
  output logic servo_from_coarse,
  output logic servo_from_fine,
  output logic integ_en,
  output logic servo_inhibit,
  // Contact solenoids
  output ats_pkg::ats_cap_t cap_sel,
  output logic [1:0] coil_short,
  output ats_pkg::ats_line_t line_sel,
  output logic rf_inhibit,
  // Status
  output logic ready,
  output logic fault,
  output logic irq
);
  import ats_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ats_state_e state;
    logic from_coarse; // Switch sequence belongs to a changeover
    logic ret_ready; // Switch sequence started from ready
    ats_range_t range; // Range now applied to the contacts
    ats_range_t pend_range; // Range waiting for the quiet window
    ats_line_t pend_line; // Line waiting for the quiet window
    ats_cap_t cap;
    logic [1:0] coil;
    ats_line_t line;
    logic integ;
    logic fault;
    logic ctrl_manual;
    logic ctrl_ovr;
    logic ctrl_srvoff;
    ats_range_t man_range;
    ats_line_t man_line;
    ats_line_t auto_line;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic tune_d; // Previous tune_req for edge detection
    logic [31:0] prdata;
    logic pslverr;
  } ats_top_s;

  ats_top_s r; // Registered state
  ats_top_s n; // Next state
  logic [1:0] clr; // Timer restarts, combinational
  logic [3:0] ev; // Events raised this cycle
  logic [31:0] ph_el; // Phase timer
  logic [31:0] wd_el; // Watchdog timer
  logic apb_setup;
  logic apb_wr;
  logic wr_start;
  logic start_ev;
  logic busy;
  logic wd_over;
  ats_range_t tgt_range;
  ats_line_t tgt_line;
  logic sel_change;

  // Address decode, used for the error answer; the read mux decodes paddr on its own
  function automatic logic ats_hit(input logic [7:0] a);
    ats_hit = (a == `ATS_CTRL_OFF) || (a == `ATS_SEL_OFF) || (a == `ATS_STAT_OFF) ||
              (a == `ATS_INT_STAT_OFF) || (a == `ATS_INT_MASK_OFF);
  endfunction

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  ats_tmr_if tmr_bus [2] ();

  // Timer 0 paces phases, timer 1 watches the whole sequence
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_tmr
      ats_timer u_tmr
      (
        .clk(clk),
        .rst(rst),
        .bus(tmr_bus[i])
      );
      assign tmr_bus[i].clr = clr[i];
    end
  endgenerate

  assign ph_el = tmr_bus[0].elapsed;
  assign wd_el = tmr_bus[1].elapsed;

  // ----------------------------------------------------------------
  // Request and selection decode
  // ----------------------------------------------------------------
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign wr_start = apb_wr & (paddr == `ATS_CTRL_OFF) & pwdata[`ATS_CTRL_START];
  // Requests are ignored in manual mode; the servos stay inhibited there
  assign start_ev = ~r.ctrl_manual & ((tune_req & ~r.tune_d) | wr_start);
  assign busy = (r.state == ST_COARSE) || (r.state == ST_FINE) ||
                (r.from_coarse && ((r.state == ST_QUIET) || (r.state == ST_MOVE)));
  assign wd_over = busy && (wd_el >= MAX_CYC);
  // Manual switches own range and line in manual mode
  assign tgt_range = r.ctrl_manual ? r.man_range : r.range;
  assign tgt_line = r.ctrl_manual ? r.man_line : r.auto_line;
  assign sel_change = (tgt_range != r.range) || (tgt_line != r.line);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    clr = 2'b00;
    ev = 4'h0;
    n.tune_d = tune_req;
    // Read data captured in the setup cycle, presented in access
    if (apb_setup)
    begin
      n.pslverr = ~ats_hit(paddr);
      case (paddr)
        `ATS_CTRL_OFF: n.prdata = {28'h0000000, r.ctrl_srvoff, r.ctrl_ovr, r.ctrl_manual, 1'b0};
        `ATS_SEL_OFF: n.prdata = {22'h000000, r.auto_line, 2'h0, r.man_line, 1'b0, r.man_range};
        `ATS_STAT_OFF: n.prdata = {17'h00000, 3'(r.state), 2'h0, r.line, 1'b0, r.range,
                                    ready, rf_inhibit, r.integ, r.fault};
        `ATS_INT_STAT_OFF: n.prdata = {28'h0000000, r.int_stat};
        `ATS_INT_MASK_OFF: n.prdata = {28'h0000000, r.int_mask};
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    // Register writes take effect in the access cycle
    if (apb_wr)
    begin
      case (paddr)
        `ATS_CTRL_OFF:
        begin
          n.ctrl_manual = pwdata[`ATS_CTRL_MANUAL];
          n.ctrl_ovr = pwdata[`ATS_CTRL_OVR];
          n.ctrl_srvoff = pwdata[`ATS_CTRL_SRVOFF];
        end
        `ATS_SEL_OFF:
        begin
          n.man_range = pwdata[`ATS_SEL_MRANGE +: 3];
          n.man_line = pwdata[`ATS_SEL_MLINE +: 2];
          n.auto_line = pwdata[`ATS_SEL_ALINE +: 2];
        end
        `ATS_INT_MASK_OFF: n.int_mask = pwdata[3:0];
        default: n.int_mask = r.int_mask;
      endcase
    end
    // Abort paths first: manual entry or an overlong sequence
    if (busy && r.ctrl_manual)
    begin
      n.state = ST_IDLE;
      n.from_coarse = 1'b0;
      n.integ = 1'b0;
    end
    else if (wd_over)
    begin
      // Sequence overran its limit: stop and flag a fault
      n.state = ST_IDLE;
      n.from_coarse = 1'b0;
      n.integ = 1'b0;
      n.fault = 1'b1;
      ev[`ATS_EV_FAULT] = 1'b1;
    end
    else
    begin
      unique case (r.state)
        ST_IDLE, ST_READY:
        begin
          if (start_ev)
          begin
            // Neutral bank before the servos move
            n.state = ST_COARSE;
            n.cap = 4'h0;
            n.coil = 2'h0;
            n.integ = 1'b0;
            n.fault = 1'b0;
            n.ret_ready = 1'b0;
            clr = 2'b11;
          end
          else if (r.state == ST_READY && r.ctrl_manual)
          begin
            n.state = ST_IDLE;
          end
          else if (sel_change)
          begin
            // Selection changes never move contacts live: quiet RF first
            n.state = ST_QUIET;
            n.from_coarse = 1'b0;
            n.ret_ready = (r.state == ST_READY);
            n.pend_range = tgt_range;
            n.pend_line = tgt_line;
            clr[0] = 1'b1;
          end
        end
        ST_COARSE:
        begin
          // Changeover only once the servo motors have stopped
          if (servo_low)
          begin
            n.state = ST_QUIET;
            n.from_coarse = 1'b1;
            n.pend_range = switch_range;
            n.pend_line = r.auto_line;
            clr[0] = 1'b1;
          end
        end
        ST_QUIET:
        begin
          // RF off long enough: operate the solenoids
          if (ph_el >= SWITCH_CYC)
          begin
            n.state = ST_MOVE;
            n.range = r.pend_range;
            n.cap = ats_cap_bits(r.pend_range);
            n.coil = ats_short_bits(r.pend_range);
            n.line = r.pend_line;
            clr[0] = 1'b1;
          end
        end
        ST_MOVE:
        begin
          // Contacts settled before RF is allowed back
          if (ph_el >= SWITCH_CYC)
          begin
            clr[0] = 1'b1;
            if (r.from_coarse)
            begin
              // Drive back to the amplifier, fine discriminators
              n.state = ST_FINE;
              n.from_coarse = 1'b0;
              ev[`ATS_EV_CHANGE] = 1'b1;
            end
            else
            begin
              n.state = r.ret_ready ? ST_READY : ST_IDLE;
              ev[`ATS_EV_SWITCH] = 1'b1;
            end
          end
        end
        ST_FINE:
        begin
          // Integrator damps hunting once the loop has pulled in
          if (ph_el >= INTEG_CYC)
          begin
            n.integ = 1'b1;
          end
          if (ph_el >= READY_CYC)
          begin
            n.state = ST_READY;
            ev[`ATS_EV_READY] = 1'b1;
          end
        end
      endcase
    end
    // Sticky events, write one to clear; a new event beats the clear
    n.int_stat = r.int_stat | ev;
    if (apb_wr && (paddr == `ATS_INT_STAT_OFF))
    begin
      n.int_stat = (r.int_stat & ~pwdata[3:0]) | ev;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.state <= ST_IDLE;
      r.man_range <= ats_range_t'(`ATS_SEL_RST);
      r.int_mask <= `ATS_MASK_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = r.prdata;
  assign pready = penable; // No wait states
  assign pslverr = psel & penable & r.pslverr;
  // Low-level drive via level_stabilising_amplifier in coarse
  assign drive_to_coarse = busy && (r.state != ST_FINE);
  assign servo_from_coarse = busy && (r.state != ST_FINE);
  // Phase drives tuning coil, amplitude the loading coil
  assign servo_from_fine = (r.state == ST_FINE) || (r.state == ST_READY);
  assign integ_en = r.integ;
  // Servos run in coarse and fine; at ready the link option decides
  assign servo_inhibit = r.ctrl_manual ||
                         !((r.state == ST_COARSE) || (r.state == ST_FINE) ||
                           ((r.state == ST_READY) && !r.ctrl_srvoff));
  assign cap_sel = r.cap;
  assign coil_short = r.coil;
  assign line_sel = r.line;
  assign rf_inhibit = (r.state == ST_QUIET) || (r.state == ST_MOVE);
  assign ready = (r.state == ST_READY) || r.ctrl_ovr;
  assign fault = r.fault;
  assign irq = |(r.int_stat & r.int_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  coarse_drive_a: assert property (
    (r.state == ST_COARSE) |-> drive_to_coarse && !servo_from_fine)
    else $error("Coarse phase without coarse drive path");
  coarse_servo_a: assert property (
    (r.state == ST_COARSE) |-> servo_from_coarse)
    else $error("Coarse phase without coarse servo inputs");
  cap_clear_a: assert property (
    (r.state != ST_COARSE) ##1 (r.state == ST_COARSE) |-> cap_sel == 4'h0 && coil_short == 2'h0)
    else $error("Capacitor bank not neutral at coarse start");
  change_gate_a: assert property (
    (r.state == ST_COARSE && !servo_low) |=> (r.state == ST_COARSE || r.state == ST_IDLE))
    else $error("Changeover before servos stopped");
  range_take_a: assert property (
    (r.state == ST_COARSE && servo_low && !wd_over && !r.ctrl_manual)
    |=> r.pend_range == $past(switch_range) ##[1:3] 1'b1)
    else $error("Changeover range not taken from switches");
  fine_path_a: assert property (
    (r.state == ST_FINE) |-> !drive_to_coarse && !servo_from_coarse && servo_from_fine)
    else $error("Fine phase with coarse routing");
  integ_early_a: assert property (
    (r.state == ST_FINE && ph_el < INTEG_CYC && $past(r.state) == ST_FINE) |-> !integ_en)
    else $error("Integrator switched in too early");
  ready_time_a: assert property (
    (r.state == ST_FINE && ph_el >= READY_CYC && !wd_over && !r.ctrl_manual)
    |=> (r.state == ST_READY) && ready)
    else $error("Ready not raised at its delay");
  ready_servo_a: assert property (
    (r.state == ST_READY && !r.ctrl_manual) |-> servo_inhibit == r.ctrl_srvoff)
    else $error("Servo state at ready ignores link option");
  manual_inhib_a: assert property (
    r.ctrl_manual |-> servo_inhibit)
    else $error("Servos live in manual mode");
  override_a: assert property (
    r.ctrl_ovr |-> ready)
    else $error("Override did not force ready");
  quiet_switch_a: assert property (
    ($changed(line_sel) || ($changed(cap_sel) && r.state != ST_COARSE)) |-> rf_inhibit)
    else $error("Contact moved with RF present");
  coil_short_a: assert property (
    (coil_short != 2'h0) |-> (r.range >= `ATS_SHORT_MIN_RANGE))
    else $error("Inductor shorted on a low range");
  watchdog_a: assert property (
    wd_over && !r.ctrl_manual |=> (r.state == ST_IDLE) && fault)
    else $error("Overlong sequence not stopped");
  start_a: assert property (
    (start_ev && (r.state == ST_IDLE || r.state == ST_READY) && !busy)
    |=> (r.state == ST_COARSE) && (ready == r.ctrl_ovr))
    else $error("Tune request did not start coarse tuning");

  reach_ready_c: cover property ((r.state == ST_FINE) ##1 (r.state == ST_READY));
  fault_c: cover property (wd_over ##1 fault);
  manual_switch_c: cover property (r.ctrl_manual && (r.state == ST_MOVE));
  irq_c: cover property ($rose(irq));

endmodule

/* File: logic/ats_top_fix_note.sv */
// Holds no logic of its own; the sequencer lives in ats_top.sv.

/* File: dv/ats_xmtr_model.sv */
// Far side: drive chain and coil motors, seen through the stopped
// detector and the position switch bank. Assumes one shared clock.
module ats_xmtr_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Routing and motor settings
  input wire logic drive_to_coarse,
  input wire logic [15:0] settle,
  input wire ats_pkg::ats_range_t range_in,
  // Detector and switch bank
  output logic servo_low,
  output ats_pkg::ats_range_t switch_range
);
  timeunit 1ns;
  timeprecision 1ps;
  import ats_pkg::*;
  logic [15:0] run_r; // Cycles the wipers have moved
  logic stop_r; // Motors at rest
  logic [2:0] chat_r; // Contact chatter while moving
  // Low drive is present through coarse tuning; motors stop after settle
  // Detector clears whenever coarse drive is away, so no stale stop survives
  always @(posedge clk)
  begin
    chat_r <= rst ? 3'h0 : chat_r + 3'h3;
    if (rst || !drive_to_coarse)
    begin
      run_r <= 16'h0;
      stop_r <= 1'b0;
    end
    else if (!stop_r)
    begin
      run_r <= run_r + 16'h1;
      stop_r <= (run_r + 16'h1 >= settle);
    end
  end
  // Switches only show the range once the wipers rest; they chatter while moving
  assign servo_low = stop_r;
  assign switch_range = stop_r ? range_in : chat_r;
endmodule

/* File: dv/testbench.sv */
// Bench for the tuning sequencer: APB registers, tuning on all ranges,
// manual mode and watchdog. Assumes ats_pkg and ats_regs.svh.
`include "ats_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ats_pkg::*;
  // ----------
  // Signals
  // ----------
  localparam int SW = 4; // Short counts keep the run small
  localparam int INTEG = 20;
  localparam int RDY = 40;
  localparam int MAXC = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tune_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, servo_low, drive_to_coarse, servo_from_coarse, servo_from_fine;
  logic integ_en, servo_inhibit, rf_inhibit, ready, fault, irq;
  logic [1:0] coil_short;
  ats_cap_t cap_sel, cap_q;
  ats_line_t line_sel, line_q;
  ats_range_t switch_range, range_in = 3'h0;
  logic [15:0] settle = 16'h0008;
  logic [32:0] exp_q[$]; // Expected {pslverr, prdata} per read
  int num_errors = 0, checked = 0, seed = 32'h798F, i, n;
  ats_top #(.SWITCH_CYC(32'(SW)), .INTEG_CYC(32'(INTEG)), .READY_CYC(32'(RDY)),
    .MAX_CYC(32'(MAXC))) dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tune_req, .servo_low, .switch_range, .drive_to_coarse,
    .servo_from_coarse, .servo_from_fine, .integ_en, .servo_inhibit, .cap_sel,
    .coil_short, .line_sel, .rf_inhibit, .ready, .fault, .irq);
  ats_xmtr_model far (.clk, .rst, .drive_to_coarse, .settle, .range_in, .servo_low,
    .switch_range);
  always #5 clk = ~clk;
  // ----------
  // Checking
  // ----------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] e);
    checked++;
    if (seen !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, seen);
    end
  endtask
  // Read results are taken as they appear; contacts move only under RF inhibit, except the cap_sel clear at coarse start
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite)
      check("read", {pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'h1_FFFF_FFFF);
    if (!rst && (line_sel !== line_q || (cap_sel !== cap_q && cap_sel !== 4'h0)))
      check("quiet switch", rf_inhibit, 1'b1);
    line_q <= line_sel;
    cap_q <= cap_sel;
  end
  // ----------
  // Drivers
  // ----------
  // One APB transfer; the request stands until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr)
      exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 100);
    if (k >= 100)
    begin
      num_errors++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: sig = rf_inhibit;
      1: sig = servo_from_fine;
      2: sig = integ_en;
      3: sig = ready;
      default: sig = fault;
    endcase
  endfunction
  // Bounded wait for one output to reach a level
  task automatic wait_sig(input int k, input logic lvl, output int c);
    c = 0;
    while (sig(k) !== lvl && c < 1000)
    begin
      @(posedge clk);
      c++;
    end
    if (c >= 1000)
    begin
      check("wait", k, 33'h1_0000_0000);
      wrap_up();
    end
  endtask
  task automatic pulse();
    tune_req <= 1'b1;
    @(posedge clk);
    tune_req <= 1'b0;
    @(posedge clk);
  endtask
  // Line change by the outside party, then one full automatic tune
  task automatic tune(input ats_range_t r, input ats_line_t l, input logic off);
    int c1;
    int c2;
    apb(1'b1, `ATS_CTRL_OFF, {28'h0, off, 3'h0}, 33'h0);
    apb(1'b1, `ATS_SEL_OFF, {22'h0, l, 8'h0}, 33'h0);
    wait_sig(0, 1'b1, c1);
    wait_sig(0, 1'b0, c1);
    check("auto line", line_sel, l);
    range_in <= r;
    settle <= 16'h3 + 16'($random(seed) & 15);
    // Odd passes start by the register start bit, even ones by the pin
    if (off)
      apb(1'b1, `ATS_CTRL_OFF, {28'h0, off, 3'h1}, 33'h0);
    else
      pulse();
    check("coarse", {drive_to_coarse, servo_from_coarse, servo_from_fine, cap_sel,
      coil_short, ready, irq}, 11'h600);
    wait_sig(1, 1'b1, c1);
    check("coarse hold", c1 >= settle + 2 * SW, 1'b1);
    check("changeover", {cap_sel, coil_short, drive_to_coarse, servo_from_coarse, line_sel},
      {4'(r) + 4'h1, (r >= 3'h6) ? 2'h3 : 2'h0, 2'h0, l});
    wait_sig(2, 1'b1, c2);
    check("integ time", c2 >= INTEG - 1 && c2 <= INTEG + 3, 1'b1);
    wait_sig(3, 1'b1, c1);
    c1 += c2;
    check("ready time", c1 >= RDY - 1 && c1 <= RDY + 3, 1'b1);
    check("servos at ready", servo_inhibit, off);
    apb(1'b0, `ATS_STAT_OFF, 32'h0, {18'h0, 3'h5, 2'h0, l, 1'b0, r, 4'hA});
    check("irq up", irq, 1'b1);
    apb(1'b1, `ATS_INT_STAT_OFF, 32'hF, 33'h0);
    check("irq clear", irq, 1'b0);
    $display("test tune range %0d done", r);
  endtask
  // ----------
  // Sequence
  // ----------
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset outs", {servo_inhibit, drive_to_coarse, cap_sel, line_sel, ready}, 9'h100);
    apb(1'b0, `ATS_SEL_OFF, 32'h0, 33'h0);
    apb(1'b0, `ATS_INT_MASK_OFF, 32'h0, 33'h0);
    apb(1'b1, `ATS_STAT_OFF, 32'hFFFF_FFFF, 33'h0);
    apb(1'b0, `ATS_STAT_OFF, 32'h0, 33'h0);
    apb(1'b0, 8'h14, 32'h0, 33'h1_0000_0000);
    apb(1'b1, `ATS_INT_MASK_OFF, 32'h1, 33'h0);
    $display("test registers done");
    for (i = 0; i < 8; i++)
      tune(3'(i), 2'(i + 1), i[0]);
    // Manual range 5, line 2, then override
    apb(1'b1, `ATS_SEL_OFF, 32'h25, 33'h0);
    apb(1'b1, `ATS_CTRL_OFF, 32'h2, 33'h0);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, n);
    check("manual", {cap_sel, coil_short, line_sel, servo_inhibit, ready}, 10'h18A);
    pulse();
    check("manual refuse", drive_to_coarse, 1'b0);
    apb(1'b1, `ATS_CTRL_OFF, 32'h6, 33'h0);
    check("override", ready, 1'b1);
    $display("test manual done");
    // Motors never stop: the watchdog ends the sequence
    apb(1'b1, `ATS_CTRL_OFF, 32'h0, 33'h0);
    wait_sig(0, 1'b1, n);
    wait_sig(0, 1'b0, n);
    apb(1'b1, `ATS_INT_STAT_OFF, 32'hF, 33'h0);
    apb(1'b1, `ATS_INT_MASK_OFF, 32'h4, 33'h0);
    settle <= 16'hFFFF;
    pulse();
    wait_sig(4, 1'b1, n);
    check("overrun time", n >= MAXC - 4 && n <= MAXC + 3, 1'b1);
    check("overrun idle", drive_to_coarse, 1'b0);
    apb(1'b0, `ATS_INT_STAT_OFF, 32'h0, 33'h4);
    check("fault irq", irq, 1'b1);
    $display("test watchdog done");
    repeat (2) @(posedge clk);
    check("reads left", exp_q.size(), 33'h0);
    wrap_up();
  end
endmodule
